// file: rtl/adcctl_pkg.sv
// constants and types shared by the converter control block
package adcctl_pkg;
    // register indices (not all multiples of four: index kept, byte address = 4 * index)
    localparam logic [7:0] IDX_RES_LOW = 8'h00_c2;
    localparam logic [7:0] IDX_RES_HIGH = 8'h00_c3;
    localparam logic [7:0] IDX_CONTROL_ZERO = 8'h00_e8;
    localparam logic [7:0] IDX_CONV_CTRL_ONE = 8'h00_e1;
    localparam logic [7:0] IDX_CMP_CTRL = 8'h00_e2;
    localparam logic [7:0] IDX_CMP_LOW = 8'h00_e3;
    localparam logic [7:0] IDX_CMP_HIGH = 8'h00_e4;
    localparam logic [7:0] IDX_ACQ_TIME = 8'h00_f2;
    localparam logic [7:0] IDX_PIN_DISC = 8'h00_f6;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'h00_d0;
    localparam logic [7:0] IDX_IRQ_MASK = 8'h00_d1;
    localparam logic [7:0] IDX_SAR_RESULT = 8'h00_d2;
    // reset values
    localparam logic [7:0] RST_CONV_CTRL_ONE = 8'h00_20;
    localparam logic [7:0] RST_BYTE = 8'h00_00;
    // field positions
    localparam int BIT_FLAG = 7;
    localparam int BIT_START = 6;
    localparam int BIT_ENABLE = 0;
    localparam int BIT_EXT_SEL = 1;
    localparam int BIT_CMP_POL = 6;
    localparam int BIT_CMP_EN = 5;
    localparam int BIT_CMP_OUT = 4;
    localparam int BIT_IRQ_DONE = 0;
    localparam int BIT_IRQ_TRIG_LOST = 1;
    // conversion timing: successive approximation bits; channel codes for band-gap and last pin
    localparam logic [3:0] SAR_STEPS = 4'h0_a;
    localparam logic [3:0] CH_BANDGAP = 4'h0_f;
    localparam logic [3:0] CH_LAST_PIN = 4'h0_7;
    // conversion sequencer states
    typedef enum logic [2:0] {
        ADCST_IDLE = 3'b001,
        ADCST_SAMPLE = 3'b010,
        ADCST_CONVERT = 3'b100
    } adcctl_state_t;
endpackage : adcctl_pkg

// file: rtl/adcctl_clkdiv.sv
// converter clock tick generator, power-of-two division
`timescale 1ns/10ps
module adcctl_clkdiv #(
    parameter int DIV_W = 3
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // control
    input wire logic run,
    input wire logic [DIV_W-1:0] divSel,
    // one-cycle tick per converter clock period
    output logic convTick
);
    logic [7:0] cnt_q;
    logic [7:0] limit;

    // divide by 2**divSel; divSel 0 ticks every cycle
    assign limit = 8'((9'h0_01 << divSel) - 9'h0_01);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cnt_q <= 8'h0_0;
            convTick <= 1'b0;
        end else if (!run) begin
            cnt_q <= 8'h0_0;
            convTick <= 1'b0;
        end else if (cnt_q >= limit) begin
            cnt_q <= 8'h0_0;
            convTick <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 8'h0_1;
            convTick <= 1'b0;
        end
    end
endmodule : adcctl_clkdiv

// file: rtl/adcctl_top.sv
// converter control: APB registers, trigger, sequencer, result and single-threshold compare
`timescale 1ns/10ps
module adcctl_top
    import adcctl_pkg::*;
#(
    parameter int RES_W = 10,
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // external trigger
    input wire logic extTriggerPin,
    // port-0 pins, raw and gated
    input wire logic [PINS-1:0] pinRaw,
    output logic [PINS-1:0] pinRead,
    // analog core interface
    output logic convClockTick,
    output logic sampleEnable,
    output logic [3:0] channelSelect,
    output logic [PINS-1:0] analogSwitch,
    output logic bandgapSelect,
    output logic [RES_W-1:0] sarTrial,
    input wire logic sarCompare,
    // interrupt
    output logic irq
);
    import adcctl_pkg::*;

    adcctl_state_t state_q;
    logic [7:0] ctrlOne_q;
    logic [3:0] chanSel_q;
    logic flag_q;
    logic cmpPol_q;
    logic cmpEn_q;
    logic cmpOut_q;
    logic [RES_W-1:0] compareValue_q;
    logic [7:0] acqTime_q;
    logic [PINS-1:0] pinDisable_q;
    logic [RES_W-1:0] convResult_q;
    logic [RES_W-1:0] sar_q;
    logic [8:0] acqCnt_q;
    logic [3:0] bitCnt_q;
    logic trigPrev_q;
    logic [1:0] irqStatus_q;
    logic [1:0] irqMask_q;
    logic convTick;
    logic apbWrite;
    logic apbRead;
    logic [7:0] regIdx;
    logic addrOk;
    logic swStart;
    logic extEdge;
    logic startReq;
    logic busy;
    logic convDone;
    logic [RES_W-1:0] sarNext;
    logic [RES_W-1:0] sarBit;
    logic [7:0] rdByte;
    logic irqClear;
    logic sarStep;
    logic flagClear;

    assign regIdx = paddr[9:2];
    assign addrOk = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
    assign apbWrite = psel && penable && pwrite && addrOk && pstrb[0];
    assign apbRead = psel && !penable && !pwrite;
    assign busy = (state_q != ADCST_IDLE);

    assign swStart = apbWrite && regIdx == IDX_CONTROL_ZERO && pwdata[BIT_START];
    assign extEdge = ctrlOne_q[BIT_EXT_SEL] && trigPrev_q && !extTriggerPin;
    // starts gated by busy, flag, enable
    assign startReq = (swStart || extEdge) && !busy && !flag_q && ctrlOne_q[BIT_ENABLE];
    // trial word reaches the core a cycle late; at divider 0 a tick
    // would judge the previous trial, so a step waits for the echo
    assign sarStep = convTick && (sarTrial == sar_q);
    assign convDone = (state_q == ADCST_CONVERT) && sarStep && (bitCnt_q == 4'h0_1);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            // idle-high level, so reset release makes no false edge
            trigPrev_q <= 1'b1;
        end else begin
            trigPrev_q <= extTriggerPin;
        end
    end

    adcctl_clkdiv #(
        .DIV_W(3)
    ) u_clkdiv (
        .ref_clk(ref_clk),
        .rst(rst),
        .run(busy),
        .divSel(ctrlOne_q[6:4]),
        .convTick(convTick)
    );

    // conversion sequencer
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_q <= ADCST_IDLE;
            acqCnt_q <= 9'h0_00;
            bitCnt_q <= 4'h0_0;
        end else begin
            case (state_q)
                ADCST_IDLE: begin
                    if (startReq) begin
                        // acquisition periods = field + 1
                        acqCnt_q <= {1'b0, acqTime_q} + 9'h0_01;
                        state_q <= ADCST_SAMPLE;
                    end
                end
                ADCST_SAMPLE: begin
                    // clearing enable aborts: no flag, no result, unless the last step falls in the cycle the enable bit first reads low
                    if (!ctrlOne_q[BIT_ENABLE]) begin
                        state_q <= ADCST_IDLE;
                    end else if (convTick) begin
                        if (acqCnt_q == 9'h0_01) begin
                            bitCnt_q <= SAR_STEPS;
                            state_q <= ADCST_CONVERT;
                        end
                        acqCnt_q <= acqCnt_q - 9'h0_01;
                    end
                end
                ADCST_CONVERT: begin
                    if (!ctrlOne_q[BIT_ENABLE]) begin
                        state_q <= ADCST_IDLE;
                    end else if (sarStep) begin
                        bitCnt_q <= bitCnt_q - 4'h0_1;
                        if (bitCnt_q == 4'h0_1) begin
                            state_q <= ADCST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= ADCST_IDLE;
                end
            endcase
        end
    end

    // successive approximation trial word
    assign sarBit = RES_W'(1) << (bitCnt_q - 4'h0_1);
    assign sarNext = sarCompare ? sar_q : (sar_q & ~sarBit);

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sar_q <= '0;
        end else if (state_q == ADCST_SAMPLE && convTick && acqCnt_q == 9'h0_01) begin
            sar_q <= RES_W'(1) << (RES_W - 1);
        end else if (state_q == ADCST_CONVERT && sarStep) begin
            if (bitCnt_q > 4'h0_1) begin
                sar_q <= sarNext | (sarBit >> 1);
            end else begin
                sar_q <= sarNext;
            end
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            convResult_q <= '0;
        end else if (convDone) begin
            convResult_q <= sarNext;
        end
    end

    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cmpOut_q <= 1'b0;
        // disabled compare keeps the last output
        end else if (convDone && cmpEn_q) begin
            cmpOut_q <= cmpPol_q ? (sarNext < compareValue_q) : (sarNext >= compareValue_q);
        end
    end

    // only a software write of 0 clears the flag
    assign flagClear = apbWrite && regIdx == IDX_CONTROL_ZERO && !pwdata[BIT_FLAG];

    // flag set wins over software clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            flag_q <= 1'b0;
        end else if (convDone) begin
            flag_q <= 1'b1;
        end else if (flagClear) begin
            flag_q <= 1'b0;
        end
    end

    // software-written control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ctrlOne_q <= RST_CONV_CTRL_ONE;
            chanSel_q <= 4'h0_0;
            cmpPol_q <= 1'b0;
            cmpEn_q <= 1'b0;
            compareValue_q <= '0;
            acqTime_q <= RST_BYTE;
            pinDisable_q <= '0;
            irqMask_q <= 2'b00;
        end else if (apbWrite) begin
            case (regIdx)
                IDX_CONTROL_ZERO: chanSel_q <= pwdata[3:0];
                // reserved bits of control one stay zero
                IDX_CONV_CTRL_ONE: ctrlOne_q <= pwdata[7:0] & 8'h0_73;
                IDX_CMP_CTRL: begin
                    cmpPol_q <= pwdata[BIT_CMP_POL];
                    cmpEn_q <= pwdata[BIT_CMP_EN];
                end
                IDX_CMP_LOW: compareValue_q[1:0] <= pwdata[1:0];
                IDX_CMP_HIGH: compareValue_q[9:2] <= pwdata[7:0];
                // no interlock: software must not change mid-conversion
                IDX_ACQ_TIME: acqTime_q <= pwdata[7:0];
                IDX_PIN_DISC: pinDisable_q <= pwdata[PINS-1:0];
                IDX_IRQ_MASK: irqMask_q <= pwdata[1:0];
                default: begin
                end
            endcase
        end
    end

    // sticky events, write one to clear; new event wins
    assign irqClear = apbWrite && regIdx == IDX_IRQ_STATUS;
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irqStatus_q <= 2'b00;
        end else begin
            irqStatus_q[BIT_IRQ_DONE] <= convDone ||
                (irqStatus_q[BIT_IRQ_DONE] && !(irqClear && pwdata[BIT_IRQ_DONE]));
            irqStatus_q[BIT_IRQ_TRIG_LOST] <= (extEdge && busy) ||
                (irqStatus_q[BIT_IRQ_TRIG_LOST] && !(irqClear && pwdata[BIT_IRQ_TRIG_LOST]));
        end
    end

    // read mux; unmapped indices read zero
    always_comb begin
        rdByte = 8'h0_0;
        case (regIdx)
            // start bit reads back as busy
            IDX_CONTROL_ZERO: rdByte = {flag_q, busy, 2'b00, chanSel_q};
            IDX_CONV_CTRL_ONE: rdByte = ctrlOne_q;
            IDX_CMP_CTRL: rdByte = {1'b0, cmpPol_q, cmpEn_q, cmpOut_q, 4'h0_0};
            IDX_CMP_LOW: rdByte = {6'h0_0, compareValue_q[1:0]};
            IDX_CMP_HIGH: rdByte = compareValue_q[9:2];
            IDX_RES_LOW: rdByte = {6'h0_0, convResult_q[1:0]};
            IDX_RES_HIGH: rdByte = convResult_q[9:2];
            IDX_ACQ_TIME: rdByte = acqTime_q;
            IDX_PIN_DISC: rdByte = pinDisable_q;
            IDX_IRQ_STATUS: rdByte = {6'h0_0, irqStatus_q};
            IDX_IRQ_MASK: rdByte = {6'h0_0, irqMask_q};
            default: rdByte = 8'h0_0;
        endcase
    end

    // registered apb answer: no wait state, data latched in setup
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel && !penable;
            // bad address answers with an error and writes nothing
            pslverr <= psel && !penable && !addrOk;
            if (apbRead) begin
                prdata <= {24'h00_0000, rdByte};
            end
        end
    end

    // pin-side and analog outputs, all registered
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            pinRead <= '0;
            convClockTick <= 1'b0;
            sampleEnable <= 1'b0;
            channelSelect <= 4'h0_0;
            analogSwitch <= '0;
            bandgapSelect <= 1'b0;
            sarTrial <= '0;
            irq <= 1'b0;
        end else begin
            pinRead <= pinRaw & ~pinDisable_q;
            convClockTick <= convTick;
            sampleEnable <= (state_q == ADCST_SAMPLE);
            channelSelect <= chanSel_q;
            // channel decode, all cut when disabled
            analogSwitch <= (ctrlOne_q[BIT_ENABLE] && chanSel_q <= CH_LAST_PIN) ?
                PINS'(1) << chanSel_q[2:0] : '0;
            bandgapSelect <= ctrlOne_q[BIT_ENABLE] && (chanSel_q == CH_BANDGAP);
            sarTrial <= sar_q;
            // level output, follows status and mask
            irq <= |(irqStatus_q & irqMask_q);
        end
    end
endmodule : adcctl_top

// file: tb/adcctl_core_model.sv
// behavioural analog core: comparator against a level set by the bench
`timescale 1ns/10ps
module adcctl_core_model (
    // trial word and input level
    input wire logic [9:0] sarTrial,
    input wire logic [9:0] level,
    // comparator answer
    output logic sarCompare
);
    // keep the trial bit while the trial does not exceed the input
    assign sarCompare = (sarTrial <= level);
endmodule : adcctl_core_model

// file: tb/adcctl_checker.sv
// port assertions for the converter control block
`timescale 1ns/10ps
module adcctl_checker #(
    parameter int PINS = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [11:0] paddr,
    input wire logic pready,
    input wire logic pslverr,
    // pins and analog side
    input wire logic [PINS-1:0] pinRaw,
    input wire logic [PINS-1:0] pinRead,
    input wire logic convClockTick,
    input wire logic sampleEnable,
    input wire logic [3:0] channelSelect,
    input wire logic [PINS-1:0] analogSwitch,
    input wire logic bandgapSelect
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    apb_answer_a: assert property (psel && !penable |=> pready && penable)
        else $error("no answer after setup");
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    bad_addr_a: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not flagged");
    pin_gate_a: assert property ((pinRead & ~$past(pinRaw)) == '0)
        else $error("pin read high without pin");
    switch_onehot_a: assert property ($onehot0(analogSwitch))
        else $error("several switches closed");
    switch_match_a: assert property (
        analogSwitch != '0 |-> channelSelect < 4'h8 && analogSwitch[channelSelect[2:0]])
        else $error("switch differs from channel");
    bandgap_code_a: assert property (bandgapSelect |-> channelSelect == 4'hf && analogSwitch == '0)
        else $error("band-gap without its code");
    sample_end_a: assert property ($fell(sampleEnable) |-> $past(convClockTick))
        else $error("sampling ended off a tick");
    cover property ($fell(sampleEnable));
    cover property (pslverr);
    cover property (bandgapSelect);
endmodule : adcctl_checker

bind adcctl_top adcctl_checker #(.PINS(PINS)) i_chk (.ref_clk(ref_clk), .rst(rst), .psel(psel),
    .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr), .pinRaw(pinRaw),
    .pinRead(pinRead), .convClockTick(convClockTick), .sampleEnable(sampleEnable),
    .channelSelect(channelSelect), .analogSwitch(analogSwitch), .bandgapSelect(bandgapSelect));

// file: tb/test_adc_control_and_compare.sv
// self-checking bench for the converter control block
`timescale 1ns/10ps
module test_adc_control_and_compare;
    import adcctl_pkg::*;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [3:0] pstrb = 4'hf;
    logic extTriggerPin = 1'b1;
    logic [7:0] pinRaw = 8'h00;
    logic [9:0] level = 10'h000;
    logic [31:0] prdata;
    logic pready, pslverr, convClockTick, sampleEnable, bandgapSelect, sarCompare, irq, err;
    logic [7:0] pinRead, analogSwitch, q;
    logic [3:0] channelSelect;
    logic [9:0] sarTrial;
    int n_fail = 0;
    int checks = 0;
    int nTick = 0;
    // ctrl2 written, level, ctrl2 expected, acquisition field
    logic [33:0] tbl [6] = '{{8'h20, 10'h2c6, 8'h30, 8'h03}, {8'h20, 10'h155, 8'h30, 8'h00},
        {8'h60, 10'h155, 8'h60, 8'h01}, {8'h60, 10'h154, 8'h70, 8'h02},
        {8'h00, 10'h000, 8'h10, 8'h00}, {8'h20, 10'h000, 8'h20, 8'h00}};

    adcctl_top i_dut (.ref_clk(ref_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .extTriggerPin(extTriggerPin), .pinRaw(pinRaw), .pinRead(pinRead),
        .convClockTick(convClockTick), .sampleEnable(sampleEnable), .channelSelect(channelSelect),
        .analogSwitch(analogSwitch), .bandgapSelect(bandgapSelect), .sarTrial(sarTrial),
        .sarCompare(sarCompare), .irq(irq));
    adcctl_core_model i_core (.sarTrial(sarTrial), .level(level), .sarCompare(sarCompare));

    always #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (sampleEnable === 1'b1 && convClockTick === 1'b1) begin
            nTick <= nTick + 1;
        end
    end

    task automatic stop_test();
        $display("checks %0d mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : stop_test

    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // entered just after a rising edge; holds the request until pready
    task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h00_0000, d};
        @(posedge ref_clk);
        penable <= 1'b1;
        do begin
            @(posedge ref_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata[7:0];
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) begin
            n_fail++;
            stop_test();
        end
        @(posedge ref_clk);
    endtask : xfer

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        xfer(1'b1, {2'h0, idx, 2'h0}, d);
    endtask : wr

    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        xfer(1'b0, {2'h0, idx, 2'h0}, 8'h00);
        chk($sformatf("reg %h", idx), q, exp);
    endtask : rd

    // samples the port after the wait, not at the call
    task automatic chkPort(input string what, input logic [7:0] exp);
        logic [7:0] v;
        repeat (2) @(posedge ref_clk);
        v = analogSwitch;
        if (what == "pin read") begin
            v = pinRead;
        end else if (what == "irq") begin
            v = {7'h00, irq};
        end else if (what == "band-gap") begin
            v = {7'h00, bandgapSelect};
        end
        chk(what, v, exp);
    endtask : chkPort

    task automatic fall();
        extTriggerPin <= 1'b0;
        repeat (3) @(posedge ref_clk);
        extTriggerPin <= 1'b1;
        repeat (3) @(posedge ref_clk);
    endtask : fall

    task automatic waitFlag();
        int n;
        n = 0;
        do begin
            xfer(1'b0, {2'h0, IDX_CONTROL_ZERO, 2'h0}, 8'h00);
            n++;
        end while (q[BIT_FLAG] !== 1'b1 && n < 200);
        if (n >= 200) begin
            n_fail++;
            stop_test();
        end
    endtask : waitFlag

    task automatic conv(input logic [33:0] t);
        int t0;
        wr(IDX_ACQ_TIME, t[7:0]);
        wr(IDX_CMP_CTRL, t[33:26]);
        level <= t[25:16];
        t0 = nTick;
        wr(IDX_CONTROL_ZERO, 8'h43);
        rd(IDX_CONTROL_ZERO, 8'h43);
        waitFlag();
        rd(IDX_CONTROL_ZERO, 8'h83);
        chk("ticks", 8'(nTick - t0), t[7:0] + 8'h01);
        rd(IDX_RES_HIGH, t[25:18]);
        rd(IDX_RES_LOW, {6'h00, t[17:16]});
        rd(IDX_CMP_CTRL, t[15:8]);
        chkPort("irq", 8'h01);
        wr(IDX_CONTROL_ZERO, 8'hc3);
        rd(IDX_CONTROL_ZERO, 8'h83);
        wr(IDX_CONTROL_ZERO, 8'h03);
        rd(IDX_CONTROL_ZERO, 8'h03);
        wr(IDX_IRQ_MASK, 8'h00);
        chkPort("irq", 8'h00);
        wr(IDX_IRQ_STATUS, 8'h01);
        wr(IDX_IRQ_MASK, 8'h01);
        chkPort("irq", 8'h00);
    endtask : conv

    initial begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        rd(IDX_CONV_CTRL_ONE, RST_CONV_CTRL_ONE);
        rd(IDX_ACQ_TIME, 8'h00);
        rd(IDX_PIN_DISC, 8'h00);
        rd(IDX_RES_HIGH, 8'h00);
        rd(IDX_RES_LOW, 8'h00);
        wr(IDX_SAR_RESULT, 8'hff);
        rd(IDX_SAR_RESULT, 8'h00);
        xfer(1'b0, 12'h3a1, 8'h00);
        chk("slave error", {7'h00, err}, 8'h01);
        pinRaw <= 8'hff;
        wr(IDX_PIN_DISC, 8'ha5);
        chkPort("pin read", 8'h5a);
        wr(IDX_PIN_DISC, 8'h00);
        chkPort("pin read", 8'hff);
        $display("test registers and pins ended");
        wr(IDX_CONV_CTRL_ONE, 8'h21);
        wr(IDX_CONTROL_ZERO, 8'h0f);
        chkPort("band-gap", 8'h01);
        wr(IDX_CONTROL_ZERO, 8'h03);
        chkPort("switch", 8'h08);
        wr(IDX_CMP_HIGH, 8'h55);
        wr(IDX_CMP_LOW, 8'h01);
        rd(IDX_CMP_HIGH, 8'h55);
        wr(IDX_IRQ_MASK, 8'h01);
        for (int i = 0; i < 6; i++) begin
            conv(tbl[i]);
        end
        // divider 0: converter clock ticks every system cycle
        wr(IDX_CONV_CTRL_ONE, 8'h01);
        conv(tbl[3]);
        $display("test conversions ended");
        fall();
        rd(IDX_CONTROL_ZERO, 8'h03);
        wr(IDX_CONV_CTRL_ONE, 8'h23);
        fall();
        rd(IDX_CONTROL_ZERO, 8'h43);
        fall();
        rd(IDX_IRQ_STATUS, 8'h02);
        waitFlag();
        rd(IDX_IRQ_STATUS, 8'h03);
        wr(IDX_CONTROL_ZERO, 8'h03);
        wr(IDX_IRQ_STATUS, 8'h03);
        rd(IDX_CONTROL_ZERO, 8'h03);
        $display("test pin trigger ended");
        wr(IDX_CONV_CTRL_ONE, 8'hff);
        rd(IDX_CONV_CTRL_ONE, 8'h73);
        wr(IDX_CONV_CTRL_ONE, 8'h22);
        wr(IDX_CONTROL_ZERO, 8'h43);
        fall();
        rd(IDX_CONTROL_ZERO, 8'h03);
        chk("switch", analogSwitch, 8'h00);
        $display("test disabled converter ended");
        stop_test();
    end
endmodule : test_adc_control_and_compare
